/* logic/pes_event_block.v */
`include "pes_defs.vh"

module pes_event_block #(
  parameter [15:0] BLOCK_BITS = 16'hFFFF
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire [7:0]  i_reg_addr,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [1:0]  i_reg_be,
  input  wire [15:0] i_reg_wdata,
  output reg  [15:0] o_reg_rdata,
  input  wire        i_alarm_irq,
  input  wire        i_power_button,
  input  wire        i_sleep_button,
  input  wire        i_counter_msb,
  input  wire        i_firmware_attention,
  input  wire        i_bus_master_req,
  input  wire [2:0]  i_sleep_state,
  input  wire        i_off_to_working,
  input  wire        i_alarm_wake_deep_flag,
  input  wire        i_interrupt_route_select,
  output wire        o_system_control_interrupt,
  output wire        o_system_management_interrupt,
  output reg         o_wake_request
);
  reg        rst_s1_q;
  reg        rst_s2_q;
  wire       rst_n;
  reg [15:0] event_status_q;
  reg [15:0] event_status_d;
  reg [15:0] event_enable_q;
  reg [15:0] event_enable_d;
  reg        msb_prev_q;
  reg        attn_prev_q;
  wire       alarm_lvl;
  wire       alarm_rise;
  wire       pwr_lvl;
  wire       pwr_rise;
  wire       slp_lvl;
  wire       slp_rise;
  wire       msb_lvl;
  wire       attn_lvl;
  wire       busm_lvl;
  wire       sleeping;
  wire       deep_sleep;
  wire       alarm_wake_ok;
  wire       wake_event;
  wire       status_hit;
  wire       pm_event;
  wire       wr_status;
  wire       wr_enable;
  wire [15:0] be_mask;
  wire [15:0] hw_set;
  wire [15:0] sw_clear;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  pes_pin_sync u_sync_alarm (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_pin     (i_alarm_irq),
    .o_level   (alarm_lvl),
    .o_rise    (alarm_rise)
  );
  pes_pin_sync u_sync_pwr (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_pin     (i_power_button),
    .o_level   (pwr_lvl),
    .o_rise    (pwr_rise)
  );
  pes_pin_sync u_sync_slp (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_pin     (i_sleep_button),
    .o_level   (slp_lvl),
    .o_rise    (slp_rise)
  );
  pes_pin_sync u_sync_msb (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_pin     (i_counter_msb),
    .o_level   (msb_lvl),
    .o_rise    ()
  );
  pes_pin_sync u_sync_attn (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_pin     (i_firmware_attention),
    .o_level   (attn_lvl),
    .o_rise    ()
  );
  pes_pin_sync u_sync_busm (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_pin     (i_bus_master_req),
    .o_level   (busm_lvl),
    .o_rise    ()
  );

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      msb_prev_q  <= 1'b0;
      attn_prev_q <= 1'b0;
    end else begin
      msb_prev_q  <= msb_lvl;
      attn_prev_q <= attn_lvl;
    end
  end

  // sleep state decode
  assign sleeping   = (i_sleep_state != `PES_SLP_S0);
  assign deep_sleep = (i_sleep_state == `PES_SLP_S4) || (i_sleep_state == `PES_SLP_S5);
  // alarm wake from s4 or s5 needs the platform flag
  assign alarm_wake_ok = ~deep_sleep | i_alarm_wake_deep_flag;

  // wake sources while sleeping; power button wakes without its enable
  assign wake_event = sleeping & (
      pwr_rise
    | (slp_rise & event_enable_q[`PES_BIT_SLPBTN])
    | (alarm_rise & event_enable_q[`PES_BIT_ALARM] & alarm_wake_ok));

  assign hw_set = {
      wake_event,
      4'h0,
      alarm_rise & (~sleeping | alarm_wake_ok),
      slp_rise,
      pwr_rise,
      2'b00,
      attn_lvl & ~attn_prev_q,
      busm_lvl,
      3'b000,
      msb_lvl ^ msb_prev_q
    } & `PES_STATUS_MASK & BLOCK_BITS;

  // byte or word writes
  assign be_mask   = {{8{i_reg_be[1]}}, {8{i_reg_be[0]}}};
  assign wr_status = i_reg_wr & (i_reg_addr == `PES_STATUS_OFS);
  assign wr_enable = i_reg_wr & (i_reg_addr == `PES_ENABLE_OFS);
  assign sw_clear  = wr_status ? (i_reg_wdata & be_mask) : 16'h0000;

  always @* begin
    // set wins over clear
    event_status_d = ((event_status_q & ~sw_clear) | hw_set)
                     & `PES_STATUS_MASK & BLOCK_BITS;
    event_enable_d = event_enable_q;
    if (i_off_to_working) begin
      event_enable_d = `PES_ENABLE_RESET;
    end else if (wr_enable) begin
      event_enable_d = ((event_enable_q & ~be_mask) | (i_reg_wdata & be_mask))
                       & `PES_ENABLE_MASK & BLOCK_BITS;
    end
  end

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      event_status_q <= `PES_STATUS_RESET;
      event_enable_q <= `PES_ENABLE_RESET;
      o_wake_request <= 1'b0;
    end else begin
      event_status_q <= event_status_d;
      event_enable_q <= event_enable_d;
      o_wake_request <= event_status_d[`PES_BIT_WAKE] & sleeping;
    end
  end

  // reads: reserved and absent bits are zero
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `PES_STATUS_OFS: o_reg_rdata <= event_status_q & be_mask;
        `PES_ENABLE_OFS: o_reg_rdata <= event_enable_q & be_mask;
        default:         o_reg_rdata <= 16'h0000;
      endcase
    end
  end

  // status ANDed with enable, held until either is cleared
  assign status_hit = (event_status_q[`PES_BIT_TIMER]  & event_enable_q[`PES_BIT_TIMER])
                    | (event_status_q[`PES_BIT_GLOBAL] & event_enable_q[`PES_BIT_GLOBAL])
                    | (event_status_q[`PES_BIT_PWRBTN] & event_enable_q[`PES_BIT_PWRBTN])
                    | (event_status_q[`PES_BIT_SLPBTN] & event_enable_q[`PES_BIT_SLPBTN])
                    | (event_status_q[`PES_BIT_ALARM]  & event_enable_q[`PES_BIT_ALARM]);
  assign pm_event = status_hit & ~sleeping;
  assign o_system_control_interrupt    = pm_event & i_interrupt_route_select;
  assign o_system_management_interrupt = pm_event & ~i_interrupt_route_select;
endmodule // pes_event_block

/* logic/pes_defs.vh */
`ifndef PES_DEFS_VH
`define PES_DEFS_VH

// event block length in bytes; enable register sits at half of it
`define PES_EVT_BLOCK_LEN      8'h04
`define PES_STATUS_OFS         8'h00
`define PES_ENABLE_OFS         8'h02

// bit positions in status; enable shares all of them except BUSM and WAKE
`define PES_BIT_TIMER          0
`define PES_BIT_BUSM           4
`define PES_BIT_GLOBAL         5
`define PES_BIT_PWRBTN         8
`define PES_BIT_SLPBTN         9
`define PES_BIT_ALARM          10
`define PES_BIT_WAKE           15

// implemented-bit masks
`define PES_STATUS_MASK        16'h8731
`define PES_ENABLE_MASK        16'h0721

`define PES_ENABLE_RESET       16'h0000
`define PES_STATUS_RESET       16'h0000

// sleep state codes on i_sleep_state
`define PES_SLP_S0             3'h0
`define PES_SLP_S4             3'h4
`define PES_SLP_S5             3'h5

`endif

/* logic/pes_pin_sync.v */
module pes_pin_sync (
  input  wire i_clk_sys,
  input  wire i_rst_n,
  input  wire i_pin,
  output reg  o_level,
  output wire o_rise
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end

  // rise counts once the second and third stages agree high
  assign o_rise = s2_q & s3_q & ~o_level;
endmodule // pes_pin_sync

/* tb/pes_event_block_monitor.sv */
module pes_event_block_monitor (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_rd,
  input wire logic [1:0]  i_reg_be,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        i_off_to_working,
  input wire logic        i_interrupt_route_select,
  input wire logic        o_system_control_interrupt,
  input wire logic        o_system_management_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_rsv; (o_reg_rdata & 16'h78CE) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read high");
  property p_en; i_reg_rd && i_reg_addr == 8'h02 |=> (o_reg_rdata & 16'hF8DE) == 16'h0000; endproperty
  a_en: assert property (p_en) else $error("enable reserved bit high");
  property p_unmap; i_reg_rd && i_reg_addr > 8'h03 |=> o_reg_rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_lo; i_reg_rd && i_reg_be == 2'b01 |=> o_reg_rdata[15:8] == 8'h00; endproperty
  a_lo: assert property (p_lo) else $error("high lane not zero");
  property p_hi; i_reg_rd && i_reg_be == 2'b10 |=> o_reg_rdata[7:0] == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("low lane not zero");
  property p_hold; !$past(i_reg_rd) |-> $stable(o_reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_sci; o_system_control_interrupt |-> i_interrupt_route_select; endproperty
  a_sci: assert property (p_sci) else $error("interrupt on wrong route");
  property p_smi; o_system_management_interrupt |-> !i_interrupt_route_select; endproperty
  a_smi: assert property (p_smi) else $error("management irq on wrong route");
  property p_off;
    i_off_to_working |=> !o_system_control_interrupt && !o_system_management_interrupt;
  endproperty
  a_off: assert property (p_off) else $error("enables not cleared");
endmodule // pes_event_block_monitor

/* tb/pes_event_block_tb.sv */
module pes_event_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, wr, rd, offw, deep, route;
  logic [7:0]  addr;
  logic [1:0]  be;
  logic [15:0] wd;
  logic [4:0]  pins;
  logic [2:0]  slp;
  wire  [15:0] rdata;
  wire         system_control_interrupt, system_management_interrupt, wake;
  int          err_count, n_checks;
  int          sb [5] = '{10, 8, 9, 0, 5};
  pes_event_block DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_be(be), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .i_alarm_irq(pins[0]), .i_power_button(pins[1]), .i_sleep_button(pins[2]),
    .i_counter_msb(pins[3]), .i_firmware_attention(pins[4]), .i_bus_master_req(1'b0),
    .i_sleep_state(slp), .i_off_to_working(offw), .i_alarm_wake_deep_flag(deep),
    .i_interrupt_route_select(route), .o_system_control_interrupt(system_control_interrupt),
    .o_system_management_interrupt(system_management_interrupt), .o_wake_request(wake));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    be <= 2'b11;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [1:0] b, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    be <= b;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    pins[i] <= 1'b1;
    repeat (8) @(posedge clk);
    pins[i] <= 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    tally_and_finish();
  end
  initial begin
    {rst_n, wr, rd, offw, deep, addr, be, wd, pins, slp} = '0;
    route = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd16(8'h00, 2'b11, 16'h0000);
    rd16(8'h02, 2'b11, 16'h0000);
    wr16(8'h02, 16'hFFFF);
    rd16(8'h02, 2'b11, 16'h0721);
    wr16(8'h04, 16'hFFFF);
    rd16(8'h04, 2'b11, 16'h0000);
    wr16(8'h02, 16'h0000);
    wr16(8'h02, 16'h0721);
    rd16(8'h02, 2'b10, 16'h0700);
    rd16(8'h02, 2'b01, 16'h0021);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      chk({15'h0000, system_control_interrupt}, 16'h0001);
      rd16(8'h00, 2'b11, 16'h0001 << sb[i]);
      wr16(8'h00, 16'h0000);
      chk({15'h0000, system_control_interrupt}, 16'h0001);
      wr16(8'h00, 16'hFFFF);
      chk({15'h0000, system_control_interrupt}, 16'h0000);
    end
    wr16(8'h02, 16'h0000);
    for (int i = 0; i < 5; i++) pulse(i);
    rd16(8'h00, 2'b11, 16'h0721);
    chk({15'h0000, system_control_interrupt}, 16'h0000);
    wr16(8'h02, 16'h0100);
    chk({15'h0000, system_control_interrupt}, 16'h0001);
    route <= 1'b0;
    @(negedge clk);
    chk({14'h0000, system_control_interrupt, system_management_interrupt}, 16'h0001);
    route <= 1'b1;
    @(posedge clk);
    offw <= 1'b1;
    @(posedge clk);
    offw <= 1'b0;
    rd16(8'h02, 2'b11, 16'h0000);
    wr16(8'h00, 16'hFFFF);
    slp <= 3'h3;
    pulse(1);
    rd16(8'h00, 2'b11, 16'h8100);
    chk({15'h0000, wake}, 16'h0001);
    wr16(8'h00, 16'hFFFF);
    rd16(8'h00, 2'b11, 16'h0000);
    chk({15'h0000, wake}, 16'h0000);
    pulse(2);
    rd16(8'h00, 2'b11, 16'h0200);
    wr16(8'h00, 16'hFFFF);
    wr16(8'h02, 16'h0400);
    slp <= 3'h4;
    pulse(0);
    rd16(8'h00, 2'b11, 16'h0000);
    deep <= 1'b1;
    pulse(0);
    rd16(8'h00, 2'b11, 16'h8400);
    tally_and_finish();
  end
endmodule // pes_event_block_tb
bind pes_event_block pes_event_block_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_be(i_reg_be), .o_reg_rdata(o_reg_rdata),
  .i_off_to_working(i_off_to_working), .i_interrupt_route_select(i_interrupt_route_select),
  .o_system_control_interrupt(o_system_control_interrupt),
  .o_system_management_interrupt(o_system_management_interrupt));
